/* common/pla_pkg.sv */
// Shared constants and bus types for the macrocell logic array
package pla_pkg;

  // ---------------------------------------------------------------
  // Array geometry
  // ---------------------------------------------------------------
  localparam int NUM_CELLS    = 8;
  localparam int NUM_FIXED_IN = 11;
  localparam int NUM_SIG      = 20;
  localparam int NUM_COLS     = 40;
  localparam int NUM_TERMS    = 90;
  localparam int WIDE_CELLS   = 4;
  localparam int WIDE_TERMS   = 12;
  localparam int NARROW_TERMS = 8;
  localparam int PRESET_TERM  = 80;
  localparam int RESET_TERM   = 81;
  localparam int OE_TERM_BASE = 82;
  localparam int CLK_COL      = 11;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] CTRL_OFFS     = 12'h000;
  localparam logic [11:0] PRELOAD_OFFS  = 12'h004;
  localparam logic [11:0] STATUS_OFFS   = 12'h008;
  localparam logic [11:0] FUSE_BASE     = 12'h400;
  localparam int          FUSE_BASE_BIT = 10;
  localparam int          POL_LSB       = 0;
  localparam int          MODE_LSB      = 8;
  localparam int          CLKSEL_BIT    = 16;
  localparam int          STAT_OE_LSB   = 8;
  localparam logic [7:0]  POL_RST       = 8'h00;
  localparam logic [7:0]  MODE_RST      = 8'h00;
  localparam logic        CLKSEL_RST    = 1'b0;
  localparam logic [39:0] FUSE_RST      = 40'hFF_FFFF_FFFF;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // ---------------------------------------------------------------
  // AXI4-Lite carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [11:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [11:0] araddr;
    logic        arvalid;
    logic        rready;
  } pla_axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pla_axi_rsp_type;

endpackage : pla_pkg

/* rtl/pla_macrocell_array.sv */
// Programmable AND/OR array with eight output macrocells and AXI4-Lite fuse access

`timescale 1ns/1ns

module pla_macrocell_array (
  // Clock and reset
  input  wire  logic                      aclk,
  input  wire  logic                      aresetn,
  // Register bus
  input  wire  pla_pkg::pla_axi_req_type  axi_req,
  output       pla_pkg::pla_axi_rsp_type  axi_rsp,
  // Device pins
  input  wire  logic [10:0]               fixed_in,
  input  wire  logic                      clk_pin,
  input  wire  logic [7:0]                io_in,
  output logic [7:0]                      io_out,
  output logic [7:0]                      io_oe
);

  // ---------------------------------------------------------------
  // Configuration state
  // ---------------------------------------------------------------
  logic [39:0] fuse_r [pla_pkg::NUM_TERMS];
  logic [7:0]  pol_r;
  logic [7:0]  mode_r;
  logic        clksel_r;
  logic [7:0]  q_r;
  logic        preload_stb;
  logic [7:0]  preload_val;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // Pins are asynchronous; a change counts only once stages two and three agree
  logic [19:0] pin_raw;
  logic [19:0] sync1_r;
  logic [19:0] sync2_r;
  logic [19:0] sync3_r;
  logic [19:0] lvl_r;
  logic        clk_prev_r;
  logic        clk_rise;

  assign pin_raw = {io_in, clk_pin, fixed_in};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= 20'h0_0000;
      sync2_r <= 20'h0_0000;
      sync3_r <= 20'h0_0000;
    end else begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lvl_r <= 20'h0_0000;
    end else begin
      lvl_r <= (sync2_r & ~(sync2_r ^ sync3_r)) | (lvl_r & (sync2_r ^ sync3_r));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_prev_r <= 1'b0;
    end else begin
      clk_prev_r <= lvl_r[pla_pkg::CLK_COL];
    end
  end

  assign clk_rise = lvl_r[pla_pkg::CLK_COL] & ~clk_prev_r & clksel_r;

  // ---------------------------------------------------------------
  // AND array
  // ---------------------------------------------------------------
  logic [19:0] sig;
  logic [39:0] cols;
  logic [7:0]  fb;
  logic [89:0] term;

  always_comb begin
    for (int c = 0; c < pla_pkg::NUM_CELLS; c++) begin
      fb[c] = mode_r[c] ? ~q_r[c] : lvl_r[12 + c];
    end
  end

  always_comb begin
    sig                    = {fb, lvl_r[11:0]};
    sig[pla_pkg::CLK_COL]  = lvl_r[pla_pkg::CLK_COL] & ~clksel_r;
    cols                   = {~sig, sig};
  end

  // Bit set means the fuse is intact; an untouched term has x and not-x, so stays low
  always_comb begin
    for (int t = 0; t < pla_pkg::NUM_TERMS; t++) begin
      term[t] = &(~fuse_r[t] | cols);
    end
  end

  // ---------------------------------------------------------------
  // OR sums and macrocells
  // ---------------------------------------------------------------
  logic [7:0] sum;
  logic       preset_t;
  logic       reset_t;
  logic [7:0] q_eff;

  function automatic int term_start(input int c);
    if (c < pla_pkg::WIDE_CELLS) begin
      return c * pla_pkg::WIDE_TERMS;
    end
    return pla_pkg::WIDE_CELLS * pla_pkg::WIDE_TERMS + (c - pla_pkg::WIDE_CELLS) * pla_pkg::NARROW_TERMS;
  endfunction : term_start

  always_comb begin
    for (int c = 0; c < pla_pkg::NUM_CELLS; c++) begin
      sum[c] = 1'b0;
      for (int k = 0; k < pla_pkg::WIDE_TERMS; k++) begin
        if (k < ((c < pla_pkg::WIDE_CELLS) ? pla_pkg::WIDE_TERMS : pla_pkg::NARROW_TERMS)) begin
          sum[c] = sum[c] | term[term_start(c) + k];
        end
      end
    end
  end

  assign preset_t = term[pla_pkg::PRESET_TERM];
  assign reset_t  = term[pla_pkg::RESET_TERM];

  // Overrides show on the registered pins in the same cycle; the flops follow one edge later
  always_comb begin
    if (reset_t) begin
      q_eff = 8'h00;
    end else if (preset_t) begin
      q_eff = 8'hFF;
    end else begin
      q_eff = q_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_r <= 8'h00;
    end else if (reset_t) begin
      q_r <= 8'h00;
    end else if (preset_t) begin
      q_r <= 8'hFF;
    end else if (preload_stb) begin
      q_r <= preload_val;
    end else if (clk_rise) begin
      q_r <= (sum & mode_r) | (q_r & ~mode_r);
    end
  end

  // Pin path is combinational on purpose: the array is a logic element
  always_comb begin
    for (int c = 0; c < pla_pkg::NUM_CELLS; c++) begin
      io_out[c] = (mode_r[c] ? q_eff[c] : sum[c]) ~^ pol_r[c];
      io_oe[c]  = term[pla_pkg::OE_TERM_BASE + c];
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------
  logic [11:0] awaddr_r;
  logic        aw_full_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        w_full_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        do_write;
  logic        wr_fuse;
  logic        wr_ok;
  logic [6:0]  wr_term;

  assign axi_rsp.awready = ~aw_full_r & ~bvalid_r;
  assign axi_rsp.wready  = ~w_full_r & ~bvalid_r;
  assign axi_rsp.bvalid  = bvalid_r;
  assign axi_rsp.bresp   = bresp_r;
  assign do_write        = aw_full_r & w_full_r & ~bvalid_r;
  assign wr_term         = awaddr_r[9:3];
  assign wr_fuse         = awaddr_r[11:10] == 2'h1 && wr_term < 7'(pla_pkg::NUM_TERMS);
  assign wr_ok           = wr_fuse || awaddr_r == pla_pkg::CTRL_OFFS || awaddr_r == pla_pkg::PRELOAD_OFFS;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      awaddr_r  <= 12'h000;
    end else if (axi_req.awvalid && axi_rsp.awready) begin
      aw_full_r <= 1'b1;
      awaddr_r  <= axi_req.awaddr;
    end else if (do_write) begin
      aw_full_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_r <= 1'b0;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
    end else if (axi_req.wvalid && axi_rsp.wready) begin
      w_full_r <= 1'b1;
      wdata_r  <= axi_req.wdata;
      wstrb_r  <= axi_req.wstrb;
    end else if (do_write) begin
      w_full_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= pla_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_ok ? pla_pkg::RESP_OKAY : pla_pkg::RESP_SLVERR;
    end else if (axi_req.bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Fuse word 0 holds columns 31:0, word 1 columns 39:32 in its low byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int t = 0; t < pla_pkg::NUM_TERMS; t++) begin
        fuse_r[t] <= pla_pkg::FUSE_RST;
      end
    end else if (do_write && wr_fuse) begin
      for (int b = 0; b < 4; b++) begin
        if (wstrb_r[b] && !awaddr_r[2]) begin
          fuse_r[wr_term][b*8 +: 8] <= wdata_r[b*8 +: 8];
        end
      end
      if (wstrb_r[0] && awaddr_r[2]) begin
        fuse_r[wr_term][39:32] <= wdata_r[7:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pol_r    <= pla_pkg::POL_RST;
      mode_r   <= pla_pkg::MODE_RST;
      clksel_r <= pla_pkg::CLKSEL_RST;
    end else if (do_write && awaddr_r == pla_pkg::CTRL_OFFS) begin
      if (wstrb_r[0]) pol_r <= wdata_r[pla_pkg::POL_LSB +: 8];
      if (wstrb_r[1]) mode_r <= wdata_r[pla_pkg::MODE_LSB +: 8];
      if (wstrb_r[2]) clksel_r <= wdata_r[pla_pkg::CLKSEL_BIT];
    end
  end

  // Preload works on a blank array too, since it bypasses the fuses
  assign preload_stb = do_write && awaddr_r == pla_pkg::PRELOAD_OFFS && wstrb_r[0];
  assign preload_val = wdata_r[7:0];

  // ---------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic [6:0]  rd_term;
  logic        rd_fuse;

  assign axi_rsp.arready = ~rvalid_r;
  assign axi_rsp.rvalid  = rvalid_r;
  assign axi_rsp.rdata   = rdata_r;
  assign axi_rsp.rresp   = rresp_r;
  assign rd_term         = axi_req.araddr[9:3];
  assign rd_fuse         = axi_req.araddr[11:10] == 2'h1 && rd_term < 7'(pla_pkg::NUM_TERMS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= pla_pkg::RESP_OKAY;
    end else if (axi_req.arvalid && axi_rsp.arready) begin
      rvalid_r <= 1'b1;
      rresp_r  <= pla_pkg::RESP_OKAY;
      rdata_r  <= 32'h0000_0000;
      if (rd_fuse) begin
        rdata_r <= axi_req.araddr[2] ? {24'h00_0000, fuse_r[rd_term][39:32]} : fuse_r[rd_term][31:0];
      end else if (axi_req.araddr == pla_pkg::CTRL_OFFS) begin
        rdata_r <= {15'h0000, clksel_r, mode_r, pol_r};
      end else if (axi_req.araddr == pla_pkg::STATUS_OFFS) begin
        rdata_r <= {16'h0000, io_oe, q_r};
      end else if (axi_req.araddr != pla_pkg::PRELOAD_OFFS) begin
        rresp_r <= pla_pkg::RESP_SLVERR;
      end
    end else if (axi_req.rready) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule : pla_macrocell_array

/* bench/pla_board_model.sv */
// Board-side pin model for the macrocell pins
`timescale 1ns/1ns

module pla_board_model (
  // Clock
  input  wire logic       aclk,
  // Board drive
  input  wire logic [7:0] drive_lvl,
  input  wire logic [7:0] drive_en,
  // Device pins
  input  wire logic [7:0] io_out,
  input  wire logic [7:0] io_oe,
  output logic      [7:0] io_in
);
  // ----------------------------------------
  // Pin resolution
  // ----------------------------------------
  logic [7:0] drv;
  logic [7:0] last_r = 8'h00;

  // Undriven pins show the inverse of their last driven level, so a stale level never passes
  assign drv = io_oe | drive_en;

  always_ff @(posedge aclk) begin
    last_r <= (drv & io_in) | (~drv & last_r);
  end

  assign io_in = (io_oe & io_out) | (~io_oe & drive_en & drive_lvl)
               | (~drv & ~last_r);
endmodule : pla_board_model

/* bench/pla_macrocell_array_asserts.sv */
// Handshake and reset checks for the macrocell array
`timescale 1ns/1ns

module pla_macrocell_array_asserts (
  // Clock and reset
  input wire logic                     aclk,
  input wire logic                     aresetn,
  // Register bus
  input wire pla_pkg::pla_axi_req_type axi_req,
  input wire pla_pkg::pla_axi_rsp_type axi_rsp,
  // Device pins
  input wire logic [10:0]              fixed_in,
  input wire logic                     clk_pin,
  input wire logic [7:0]               io_in,
  input wire logic [7:0]               io_out,
  input wire logic [7:0]               io_oe
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking dc @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_rst_pins: assert property ($rose(aresetn) |-> io_oe == 8'h00 && io_out == 8'hFF)
    else $error("pins not idle after reset");
  chk_wr_answer: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
    |=> !axi_rsp.bvalid ##1 axi_rsp.bvalid) else $error("write response late");
  chk_b_hold: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write response dropped");
  chk_b_drop: assert property (axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid)
    else $error("write response repeated");
  chk_b_block: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
    else $error("write taken while busy");
  chk_rd_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read response late");
  chk_r_drop: assert property (axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid)
    else $error("read response repeated");
  chk_r_block: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("read taken while busy");

  cov_slverr: cover property (axi_rsp.bvalid && axi_rsp.bresp == pla_pkg::RESP_SLVERR);
  cov_read: cover property (axi_rsp.rvalid && axi_rsp.rresp == pla_pkg::RESP_OKAY);
  cov_oe: cover property (io_oe != 8'h00);
endmodule : pla_macrocell_array_asserts

bind pla_macrocell_array pla_macrocell_array_asserts u_pla_macrocell_array_asserts (
  .aclk, .aresetn, .axi_req, .axi_rsp, .fixed_in, .clk_pin, .io_in, .io_out, .io_oe
);

/* bench/pla_macrocell_array_tb.sv */
// Self-checking bench for the macrocell array
`timescale 1ns/1ns

module pla_macrocell_array_tb;
  // ----------------------------------------
  // Bench state
  // ----------------------------------------
  logic                     aclk;
  logic                     aresetn;
  pla_pkg::pla_axi_req_type req;
  pla_pkg::pla_axi_rsp_type rsp;
  logic [10:0]              fx;
  logic                     ck;
  logic [7:0]               io_in;
  logic [7:0]               io_out;
  logic [7:0]               io_oe;
  logic [7:0]               lvl;
  logic [7:0]               den;
  int                       failures;
  int                       tests_run;

  always #50 aclk = ~aclk;

  pla_macrocell_array u_pla_macrocell_array (.aclk, .aresetn, .axi_req(req), .axi_rsp(rsp),
    .fixed_in(fx), .clk_pin(ck), .io_in, .io_out, .io_oe);
  pla_board_model u_pla_board_model (.aclk, .drive_lvl(lvl), .drive_en(den), .io_out, .io_oe, .io_in);

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic results;
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  task automatic tmo(input int n);
    if (n >= 40) begin
      failures++;
      results();
    end
  endtask : tmo

  task automatic w(input int n);
    repeat (n) @(posedge aclk);
  endtask : w

  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] e = pla_pkg::RESP_OKAY);
    int n;
    n = 0;
    req.awaddr <= a;
    req.wdata <= v;
    req.awvalid <= 1'h1;
    req.wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (rsp.awready) req.awvalid <= 1'h0;
      if (rsp.wready) req.wvalid <= 1'h0;
    end while (rsp.bvalid !== 1'h1 && n < 40);
    tmo(n);
    chk(32'(rsp.bresp), 32'(e));
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] v, input logic [1:0] e = pla_pkg::RESP_OKAY);
    int n;
    n = 0;
    req.araddr <= a;
    req.arvalid <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (rsp.arready) req.arvalid <= 1'h0;
    end while (rsp.rvalid !== 1'h1 && n < 40);
    tmo(n);
    chk(rsp.rdata, v);
    chk(32'(rsp.rresp), 32'(e));
  endtask : rd

  // Connects a single column, below 32, to one term
  task automatic fuse(input int t, input int c);
    wr(pla_pkg::FUSE_BASE + 12'(t * 8), 32'h1 << c);
    wr(pla_pkg::FUSE_BASE + 12'(t * 8 + 4), 32'h0);
  endtask : fuse

  // Pin is synced, so each level is held well past the filter
  task automatic pulse;
    ck <= 1'h1;
    w(8);
    ck <= 1'h0;
    w(8);
  endtask : pulse

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk(32'(io_oe), 32'h0);
    chk(32'(io_out), 32'hFF);
    rd(pla_pkg::CTRL_OFFS, 32'h0);
    rd(pla_pkg::STATUS_OFFS, 32'h0);
    rd(12'h6CC, 32'hFF);
    rd(12'h6D0, 32'h0, pla_pkg::RESP_SLVERR);
    wr(12'h00C, 32'h0, pla_pkg::RESP_SLVERR);
  endtask : t_reset

  task automatic t_comb;
    fuse(11, 2);
    fuse(55, 3);
    fuse(24, 11);
    fuse(82, 1);
    fuse(12, 12);
    wr(pla_pkg::CTRL_OFFS, 32'hFF);
    fx <= 11'h00E;
    ck <= 1'h1;
    w(12);
    chk(32'(io_oe), 32'h01);
    chk(32'(io_out), 32'h17);
    fx <= 11'h008;
    ck <= 1'h0;
    lvl <= 8'h01;
    den <= 8'h01;
    w(12);
    chk(32'(io_oe), 32'h00);
    chk(32'(io_out), 32'h12);
    wr(pla_pkg::CTRL_OFFS, 32'hFE);
    w(2);
    chk(32'(io_out), 32'h13);
  endtask : t_comb

  task automatic t_reg;
    fx <= 11'h000;
    den <= 8'h00;
    fuse(0, 12);
    wr(pla_pkg::PRELOAD_OFFS, 32'hA5);
    rd(pla_pkg::STATUS_OFFS, 32'hA5);
    wr(pla_pkg::CTRL_OFFS, 32'h101FF);
    w(2);
    chk(32'(io_out), 32'h01);
    pulse();
    rd(pla_pkg::STATUS_OFFS, 32'hA4);
    chk(32'(io_out), 32'h02);
    // Clock pin back to plain input: no capture
    wr(pla_pkg::CTRL_OFFS, 32'h1FF);
    pulse();
    rd(pla_pkg::STATUS_OFFS, 32'hA4);
  endtask : t_reg

  task automatic t_async;
    fuse(80, 4);
    fuse(81, 5);
    wr(pla_pkg::PRELOAD_OFFS, 32'h0);
    fx <= 11'h010;
    w(8);
    rd(pla_pkg::STATUS_OFFS, 32'hFF);
    chk(32'(io_out), 32'h01);
    fx <= 11'h030;
    w(8);
    rd(pla_pkg::STATUS_OFFS, 32'h0);
    fx <= 11'h000;
    w(8);
  endtask : t_async

  // Mid-run reset must clear the flops and restore blank fuses
  task automatic t_rst;
    wr(pla_pkg::PRELOAD_OFFS, 32'h5A);
    rd(pla_pkg::STATUS_OFFS, 32'h5A);
    aresetn <= 1'h0;
    w(3);
    aresetn <= 1'h1;
    w(1);
    chk(32'(io_out), 32'hFF);
    rd(pla_pkg::STATUS_OFFS, 32'h0);
    rd(pla_pkg::FUSE_BASE, 32'hFFFF_FFFF);
  endtask : t_rst

  initial begin
    aclk = 1'h0;
    aresetn = 1'h0;
    req = '0;
    req.wstrb = 4'hF;
    req.bready = 1'h1;
    req.rready = 1'h1;
    fx = '0;
    ck = 1'h0;
    lvl = 8'h00;
    den = 8'h00;
    failures = 0;
    tests_run = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_reset();
    t_comb();
    t_reg();
    t_async();
    t_rst();
    results();
  end
endmodule : pla_macrocell_array_tb
